// ---- vit_pkg.sv ----
// constants, register map and carrier types of the vectored interrupt and trap front end
// Operation
// - thirty-two request nodes, each with one of sixteen priority levels
// - vectored service pushes instruction pointer and status word, plus code segment when segmented
// - event transfer moves one byte or word within pages 0-3, eight channels
// - event transfer stalls one instruction cycle and saves no status
// - event transfers share arbitration, only at the two highest levels
// - hardware traps, the nmi pin among them, win at once and save status
// - software trap takes its vector from a seven-bit trap number
// - vector address is trap number times four
// - all class B exceptions share one vector, cause flags record which
// - each node has a control register with request, enable and priority
// - shared nodes take several sources, the peripheral flags tell the cause
// - service branches straight to the node's fixed vector
// - vectors sit at the lowest addresses of code segment 0
// - software setting a request flag requests exactly like hardware
// - fast external nodes use trap numbers 18h-1Bh, vectors from 0060h
// - other nodes use fixed numbers 22h-4Fh, vectors 0088h-013Ch
// - fast external inputs are alternate port pin functions
// - clock supervision and real time clock share one node via subnode register
// - at instruction end pick the highest request, serve only above cpu level
// - control status in low byte; upper byte reads zero, ignores writes
// - software trap routine runs at the current cpu priority
package vit_pkg;
	localparam int NODES = 32;
	localparam int CHANNELS = 8;
	localparam logic [11:0] OFS_NODE_LAST = 12'h07C;
	localparam logic [11:0] OFS_CPU_PRIO = 12'h080;
	localparam logic [11:0] OFS_TRAP_FLAGS = 12'h084;
	localparam logic [11:0] OFS_EVT_CTRL = 12'h088;
	localparam logic [11:0] OFS_SUBNODE = 12'h08C;
	localparam logic [11:0] OFS_CHAN_BASE = 12'h0A0;
	localparam logic [7:0] NODE_CTRL_RESET = 8'h00;
	localparam logic [3:0] EVENT_MIN_LEVEL = 4'hE;
	localparam int SUBNODE_IDX = 27;
	// trap cause flag positions
	localparam int TF_NMI = 0;
	localparam int TF_STKOF = 1;
	localparam int TF_STKUF = 2;
	localparam int TF_CLASSB = 3;
	localparam logic [6:0] TRAP_NMI = 7'h02;
	localparam logic [6:0] TRAP_STKOF = 7'h04;
	localparam logic [6:0] TRAP_STKUF = 7'h06;
	localparam logic [6:0] TRAP_CLASSB = 7'h0A;
	localparam logic [6:0] NODE_TRAP [NODES] = '{
		7'h18, 7'h19, 7'h1A, 7'h1B, 7'h22, 7'h23, 7'h24, 7'h28,
		7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h30,
		7'h31, 7'h32, 7'h33, 7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3D,
		7'h3E, 7'h3F, 7'h40, 7'h43, 7'h47, 7'h4D, 7'h4E, 7'h4F};
	localparam logic [1:0] PUSH_FLAT = 2'h2;
	localparam logic [1:0] PUSH_SEG = 2'h3;
	typedef enum logic [2:0] {
		KIND_VECTOR = 3'b001,
		KIND_EVENT = 3'b010,
		KIND_TRAP = 3'b100
	} vit_kind_t;
	typedef struct packed {
		logic req;
		logic en;
		logic [3:0] lvl;
		logic [1:0] grp;
	} vit_node_ctrl_t;
	typedef struct packed {
		logic valid;
		vit_kind_t kind;
		logic [6:0] trap_num;
		logic [8:0] vector;
		logic [1:0] push_words;
		logic set_level;
		logic [3:0] new_level;
		logic [2:0] channel;
		logic [15:0] src;
		logic [15:0] dst;
		logic byte_move;
	} vit_svc_t;
endpackage

// ---- vit_top.sv ----
// vectored interrupt and trap front end with apb register file
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module vit_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instr_end,
	input wire logic seg_mode,
	input wire logic [31:0] periph_req,
	input wire logic [3:0] fast_pin,
	input wire logic [3:0] fast_alt_en,
	input wire logic nmi_pin_n,
	input wire logic stk_overflow,
	input wire logic stk_underflow,
	input wire logic [4:0] classb_evt,
	input wire logic sw_trap_req,
	input wire logic [6:0] sw_trap_num,
	input wire logic clk_sup_evt,
	input wire logic rtc_evt,
	output vit_pkg::vit_svc_t svc,
	output logic exec_stall,
	output logic [3:0] cpu_level
);
	// ----------------------------------------
	// register storage
	// ----------------------------------------
	vit_pkg::vit_node_ctrl_t node_ff [vit_pkg::NODES];
	logic [3:0] cpu_lvl_ff;
	logic gie_ff;
	logic [7:0] trap_flags_ff;
	logic [7:0] trap_pend_ff;
	logic [7:0] chan_en_ff;
	logic [7:0] chan_byte_ff;
	logic [3:0] subnode_ff;
	logic [31:0] chan_ptr_ff [vit_pkg::CHANNELS];
	logic sw_pend_ff;
	logic [6:0] sw_num_ff;
	logic [31:0] prdata_ff;
	vit_pkg::vit_svc_t svc_ff;
	logic [2:0] nmi_sync_ff;
	logic [3:0] fast_s1_ff;
	logic [3:0] fast_s2_ff;
	logic [3:0] fast_s3_ff;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire bus_setup = psel && !penable;
	wire bus_wr = psel && penable && pwrite;
	wire in_nodes = paddr <= vit_pkg::OFS_NODE_LAST;
	wire in_chan = paddr[11:5] == vit_pkg::OFS_CHAN_BASE[11:5];
	wire [4:0] node_sel = paddr[6:2];
	wire [2:0] chan_sel = paddr[4:2];
	wire hit_cpu = paddr == vit_pkg::OFS_CPU_PRIO;
	wire hit_tf = paddr == vit_pkg::OFS_TRAP_FLAGS;
	wire hit_evt = paddr == vit_pkg::OFS_EVT_CTRL;
	wire hit_sub = paddr == vit_pkg::OFS_SUBNODE;
	wire addr_ok = (in_nodes || in_chan || hit_cpu || hit_tf || hit_evt || hit_sub) && paddr[1:0] == 2'h0;
	wire wr_low = bus_wr && addr_ok && pstrb[0];
	wire wr_high = bus_wr && addr_ok && pstrb[1];
	wire wr_this_any = wr_low && in_nodes;
	wire [31:0] rd_node = {24'h0000_00, node_ff[node_sel]};
	wire [31:0] rd_mux = in_nodes ? rd_node :
		in_chan ? chan_ptr_ff[chan_sel] :
		hit_cpu ? {27'h000_0000, gie_ff, cpu_lvl_ff} :
		hit_tf ? {24'h0000_00, trap_flags_ff} :
		hit_evt ? {16'h0000, chan_byte_ff, chan_en_ff} :
		hit_sub ? {28'h000_0000, subnode_ff} : 32'h0000_0000;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_ff;

	// ----------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------
	wire nmi_fall = !nmi_sync_ff[1] && nmi_sync_ff[2];
	// edge taken from stages two and three so the first stage feeds only the second
	wire [3:0] fast_rise = fast_s2_ff & ~fast_s3_ff & fast_alt_en;
	wire sub_clk_hit = clk_sup_evt && subnode_ff[0];
	wire sub_rtc_hit = rtc_evt && subnode_ff[2];
	wire [31:0] sub_vec = {4'h0, sub_clk_hit || sub_rtc_hit, 27'h000_0000};
	wire [31:0] hw_evt = periph_req | {28'h000_0000, fast_rise} | sub_vec;

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	logic found;
	logic [4:0] best_idx;
	logic [5:0] best_key;
	always_comb begin
		found = 1'b0;
		best_idx = 5'h00;
		best_key = 6'h00;
		for (int i = 0; i < vit_pkg::NODES; i++) begin
			// strict compare keeps the lowest node on a full tie
			if (node_ff[i].req && node_ff[i].en && (!found || {node_ff[i].lvl, node_ff[i].grp} > best_key)) begin
				found = 1'b1;
				best_idx = 5'(i);
				best_key = {node_ff[i].lvl, node_ff[i].grp};
			end
		end
	end
	wire [3:0] best_lvl = best_key[5:2];
	wire [2:0] best_chan = {best_key[2], best_key[1:0]};
	wire trap_any = |trap_pend_ff;
	wire trap_go = trap_any;
	wire sw_go = sw_pend_ff && !trap_any;
	wire int_go = instr_end && gie_ff && found && best_lvl > cpu_lvl_ff && !trap_any && !sw_pend_ff;
	wire evt_sel = best_lvl >= vit_pkg::EVENT_MIN_LEVEL && chan_en_ff[best_chan];
	wire vec_go = int_go && !evt_sel;
	wire evt_go = int_go && evt_sel;
	wire [6:0] trap_pick = trap_pend_ff[vit_pkg::TF_NMI] ? vit_pkg::TRAP_NMI :
		trap_pend_ff[vit_pkg::TF_STKOF] ? vit_pkg::TRAP_STKOF :
		trap_pend_ff[vit_pkg::TF_STKUF] ? vit_pkg::TRAP_STKUF : vit_pkg::TRAP_CLASSB;
	wire [7:0] trap_clr = trap_pend_ff[vit_pkg::TF_NMI] ? 8'h01 :
		trap_pend_ff[vit_pkg::TF_STKOF] ? 8'h02 :
		trap_pend_ff[vit_pkg::TF_STKUF] ? 8'h04 : 8'hF8;
	wire [7:0] trap_evt = {classb_evt, stk_underflow, stk_overflow, nmi_fall};
	wire [1:0] push_n = seg_mode ? vit_pkg::PUSH_SEG : vit_pkg::PUSH_FLAT;
	wire [31:0] best_ptr = chan_ptr_ff[best_chan];

	// ----------------------------------------
	// service record
	// ----------------------------------------
	vit_pkg::vit_svc_t nxt_svc;
	always_comb begin
		nxt_svc = '0;
		nxt_svc.kind = vit_pkg::KIND_TRAP;
		if (trap_go) begin
			nxt_svc.valid = 1'b1;
			nxt_svc.trap_num = trap_pick;
			nxt_svc.push_words = push_n;
		end else if (sw_go) begin
			nxt_svc.valid = 1'b1;
			nxt_svc.trap_num = sw_num_ff;
			nxt_svc.push_words = push_n;
		end else if (vec_go) begin
			nxt_svc.valid = 1'b1;
			nxt_svc.kind = vit_pkg::KIND_VECTOR;
			nxt_svc.trap_num = vit_pkg::NODE_TRAP[best_idx];
			nxt_svc.push_words = push_n;
			nxt_svc.set_level = 1'b1;
			nxt_svc.new_level = best_lvl;
		end else if (evt_go) begin
			nxt_svc.valid = 1'b1;
			nxt_svc.kind = vit_pkg::KIND_EVENT;
			nxt_svc.trap_num = vit_pkg::NODE_TRAP[best_idx];
			nxt_svc.channel = best_chan;
			nxt_svc.src = best_ptr[15:0];
			nxt_svc.dst = best_ptr[31:16];
			nxt_svc.byte_move = chan_byte_ff[best_chan];
		end
		// segment 0 lowest addresses, four bytes per entry
		nxt_svc.vector = {nxt_svc.trap_num, 2'b00};
	end
	assign svc = svc_ff;
	assign exec_stall = svc_ff.valid && svc_ff.kind == vit_pkg::KIND_EVENT;
	assign cpu_level = cpu_lvl_ff;

	// ----------------------------------------
	// node control registers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < vit_pkg::NODES; g++) begin : gen_node
			wire wr_this = wr_low && in_nodes && node_sel == 5'(g);
			wire acc_this = int_go && best_idx == 5'(g);
			vit_pkg::vit_node_ctrl_t nxt_node;
			always_comb begin
				nxt_node = node_ff[g];
				if (wr_this) begin
					nxt_node = pwdata[7:0];
				end else if (acc_this) begin
					nxt_node.req = 1'b0;
				end
				if (hw_evt[g]) begin
					nxt_node.req = 1'b1;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					node_ff[g] <= vit_pkg::NODE_CTRL_RESET;
				end else begin
					node_ff[g] <= nxt_node;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// event transfer channel pointers
	// ----------------------------------------
	generate
		for (g = 0; g < vit_pkg::CHANNELS; g++) begin : gen_chan
			wire wr_ch = bus_wr && addr_ok && in_chan && chan_sel == 3'(g);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_ptr_ff[g] <= 32'h0000_0000;
				end else if (wr_ch) begin
					for (int b = 0; b < 4; b++) begin
						if (pstrb[b]) begin
							chan_ptr_ff[g][b*8 +: 8] <= pwdata[b*8 +: 8];
						end
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// global state
	// ----------------------------------------
	wire [3:0] nxt_cpu_lvl = vec_go ? best_lvl : (wr_low && hit_cpu) ? pwdata[3:0] : cpu_lvl_ff;
	wire nxt_gie = (wr_low && hit_cpu) ? pwdata[4] : gie_ff;
	// write one to clear, a new cause in the same cycle stays set
	wire [7:0] tf_clr = (wr_low && hit_tf) ? pwdata[7:0] : 8'h00;
	wire [7:0] nxt_trap_flags = (trap_flags_ff & ~tf_clr) | trap_evt;
	wire [7:0] nxt_trap_pend = (trap_pend_ff & ~(trap_go ? trap_clr : 8'h00)) | trap_evt;
	wire [3:0] sub_wr = (wr_low && hit_sub) ? pwdata[3:0] : subnode_ff;
	wire [3:0] nxt_subnode = sub_wr | {rtc_evt, 1'b0, clk_sup_evt, 1'b0};
	wire nxt_sw_pend = sw_trap_req || (sw_pend_ff && !sw_go);
	// a request in the cycle the pending one is served starts a fresh trap with its own number
	wire [6:0] nxt_sw_num = (sw_trap_req && (!sw_pend_ff || sw_go)) ? sw_trap_num : sw_num_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_lvl_ff <= 4'h0;
			gie_ff <= 1'b0;
			trap_flags_ff <= 8'h00;
			trap_pend_ff <= 8'h00;
			subnode_ff <= 4'h0;
			sw_pend_ff <= 1'b0;
			sw_num_ff <= 7'h00;
		end else begin
			cpu_lvl_ff <= nxt_cpu_lvl;
			gie_ff <= nxt_gie;
			trap_flags_ff <= nxt_trap_flags;
			trap_pend_ff <= nxt_trap_pend;
			subnode_ff <= nxt_subnode;
			sw_pend_ff <= nxt_sw_pend;
			sw_num_ff <= nxt_sw_num;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_en_ff <= 8'h00;
			chan_byte_ff <= 8'h00;
		end else begin
			if (wr_low && hit_evt) begin
				chan_en_ff <= pwdata[7:0];
			end
			if (wr_high && hit_evt) begin
				chan_byte_ff <= pwdata[15:8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			svc_ff <= '0;
		end else begin
			// read data captured in setup so the access phase needs no wait state
			if (bus_setup) begin
				prdata_ff <= (addr_ok && !pwrite) ? rd_mux : 32'h0000_0000;
			end
			svc_ff <= nxt_svc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_sync_ff <= 3'b111;
			fast_s1_ff <= 4'h0;
			fast_s2_ff <= 4'h0;
			fast_s3_ff <= 4'h0;
		end else begin
			nmi_sync_ff <= {nmi_sync_ff[1:0], nmi_pin_n};
			fast_s1_ff <= fast_pin;
			fast_s2_ff <= fast_s1_ff;
			fast_s3_ff <= fast_s2_ff;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_trap_wins: assert property (@(posedge pclk) disable iff (!presetn)
		trap_any |=> svc_ff.valid && svc_ff.kind == vit_pkg::KIND_TRAP && svc_ff.push_words != 2'h0)
		else $error("pending trap not serviced next cycle");
	a_classb_shared: assert property (@(posedge pclk) disable iff (!presetn)
		(|trap_pend_ff[7:3]) && !(|trap_pend_ff[2:0]) |=> svc_ff.trap_num == 7'h0A && trap_pend_ff[7:3] == 5'h00)
		else $error("class b trap did not use common vector");
	a_vector_times4: assert property (@(posedge pclk) disable iff (!presetn)
		svc_ff.valid |-> svc_ff.vector == {svc_ff.trap_num, 2'b00})
		else $error("vector is not trap number times four");
	a_ctx_push: assert property (@(posedge pclk) disable iff (!presetn)
		vec_go |=> svc_ff.push_words == ($past(seg_mode) ? 2'h3 : 2'h2) && cpu_lvl_ff == svc_ff.new_level)
		else $error("wrong context push or level on vectored entry");
	a_event_nosave: assert property (@(posedge pclk) disable iff (!presetn)
		evt_go |=> exec_stall && svc_ff.push_words == 2'h0 && !svc_ff.set_level ##1 !exec_stall || $past(evt_go))
		else $error("event transfer saved status or stalled too long");
	a_event_level: assert property (@(posedge pclk) disable iff (!presetn)
		exec_stall |-> $past(best_lvl) >= 4'hE)
		else $error("event transfer below the two highest levels");
	a_serve_above: assert property (@(posedge pclk) disable iff (!presetn)
		svc_ff.valid && svc_ff.kind != vit_pkg::KIND_TRAP |-> $past(instr_end) && $past(best_lvl) > $past(cpu_lvl_ff))
		else $error("interrupt served without priority above cpu");
	a_req_cleared: assert property (@(posedge pclk) disable iff (!presetn)
		int_go && !hw_evt[best_idx] && !wr_low |=> !node_ff[$past(best_idx)].req)
		else $error("accepted request flag not cleared");
	a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
		bus_setup && !pwrite && in_nodes |=> prdata_ff[31:8] == 24'h0000_00)
		else $error("control register upper byte not zero");
	a_sw_level: assert property (@(posedge pclk) disable iff (!presetn)
		sw_go |=> svc_ff.trap_num == $past(sw_num_ff) && !svc_ff.set_level)
		else $error("software trap changed level or number");
	a_sw_set_req: assert property (@(posedge pclk) disable iff (!presetn)
		wr_this_any && pwdata[7] |=> node_ff[$past(node_sel)].req)
		else $error("software set of request flag lost");
	// set beats clear everywhere, so these hold under any software traffic
	a_nmi_flag: assert property (@(posedge pclk) disable iff (!presetn)
		nmi_fall |=> trap_flags_ff[vit_pkg::TF_NMI] && trap_pend_ff[vit_pkg::TF_NMI])
		else $error("nmi edge not recorded");
	a_nmi_first: assert property (@(posedge pclk) disable iff (!presetn)
		trap_pend_ff[vit_pkg::TF_NMI] |=> svc_ff.valid && svc_ff.trap_num == vit_pkg::TRAP_NMI)
		else $error("nmi trap not taken first");
	a_stkof_flag: assert property (@(posedge pclk) disable iff (!presetn)
		stk_overflow |=> trap_flags_ff[vit_pkg::TF_STKOF] && trap_pend_ff[vit_pkg::TF_STKOF])
		else $error("stack overflow not recorded");
	a_classb_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(|classb_evt) |=> (trap_flags_ff[7:3] & $past(classb_evt)) == $past(classb_evt))
		else $error("class b cause flag not recorded");
	a_trap_status: assert property (@(posedge pclk) disable iff (!presetn)
		svc_ff.valid && svc_ff.kind == vit_pkg::KIND_TRAP |-> !svc_ff.set_level && svc_ff.push_words != 2'h0)
		else $error("trap entry without status save or with level change");
	a_trap_level: assert property (@(posedge pclk) disable iff (!presetn)
		sw_go || trap_go |=> cpu_lvl_ff == $past(cpu_lvl_ff) || $past(wr_low && hit_cpu))
		else $error("trap entry changed cpu level");
	a_gie_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!gie_ff |=> !svc_ff.valid || svc_ff.kind == vit_pkg::KIND_TRAP)
		else $error("node served with global enable off");
	a_instr_end_only: assert property (@(posedge pclk) disable iff (!presetn)
		!trap_any && !sw_pend_ff && !instr_end |=> !svc_ff.valid)
		else $error("node served outside an instruction end");
	a_node_range: assert property (@(posedge pclk) disable iff (!presetn)
		svc_ff.valid && svc_ff.kind != vit_pkg::KIND_TRAP |->
			(svc_ff.vector >= 9'h060 && svc_ff.vector <= 9'h06C) || (svc_ff.vector >= 9'h088 && svc_ff.vector <= 9'h13C))
		else $error("node vector outside the node table");
	a_fast_vector: assert property (@(posedge pclk) disable iff (!presetn)
		vec_go && best_idx < 5'h04 |=> svc_ff.vector == 9'h060 + {5'h00, $past(best_idx[1:0]), 2'b00})
		else $error("fast external node took the wrong vector");
	a_fast_set: assert property (@(posedge pclk) disable iff (!presetn)
		(|fast_rise) |=>
			({node_ff[3].req, node_ff[2].req, node_ff[1].req, node_ff[0].req} & $past(fast_rise)) == $past(fast_rise))
		else $error("fast pin edge did not raise its request");
	a_subnode_req: assert property (@(posedge pclk) disable iff (!presetn)
		sub_clk_hit || sub_rtc_hit |=> node_ff[vit_pkg::SUBNODE_IDX].req)
		else $error("shared node request lost");
	a_subnode_flag: assert property (@(posedge pclk) disable iff (!presetn)
		clk_sup_evt |=> subnode_ff[1])
		else $error("clock supervision flag not recorded");
	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_this_any && !hw_evt[node_sel] |=> node_ff[$past(node_sel)] == $past(pwdata[7:0]))
		else $error("control register write not taken from low byte");
endmodule
`default_nettype wire

// ---- vit_cpu_model.sv ----
// behavioural cpu core that marks instruction ends for the trap front end
`timescale 1ns/1ps
`default_nettype none
module vit_cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic exec_stall,
	input wire logic slow,
	output logic instr_end
);
	// ----------------------------------------
	// instruction pacing
	// ----------------------------------------
	logic [1:0] cnt_ff;
	// slow mode ends an instruction every third cycle, so arbitration is not always at hand
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 2'h0;
			instr_end <= 1'h0;
		end else begin
			cnt_ff <= (cnt_ff == 2'h2 || !slow) ? 2'h0 : cnt_ff + 2'h1;
			instr_end <= !exec_stall && (!slow || cnt_ff == 2'h2);
		end
	end
endmodule
`default_nettype wire

// ---- vit_top_test.sv ----
// self-checking bench of the vectored interrupt and trap front end
`timescale 1ns/1ps
`default_nettype none
module vit_top_test;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, periph_req = 32'h0, sd;
	logic [3:0] pstrb = 4'hF, fast_pin = 4'h0, fast_alt_en = 4'h0, cpu_level, lv;
	logic pready, pslverr, instr_end, exec_stall, seg_mode = 1'h0, slow = 1'h0, nmi_pin_n = 1'h1;
	logic stk_overflow = 1'h0, stk_underflow = 1'h0, sw_trap_req = 1'h0, clk_sup_evt = 1'h0, rtc_evt = 1'h0;
	logic [4:0] classb_evt = 5'h0;
	logic [6:0] sw_trap_num = 7'h0;
	logic [1:0] gp;
	logic [2:0] ch;
	logic [7:0] bm;
	vit_pkg::vit_svc_t svc;
	int n_errors = 0, compares = 0, cycles = 0;
	logic [63:0] expq[$];
	wire logic is_evt;
	wire logic [63:0] seen;
	assign is_evt = svc.kind === vit_pkg::KIND_EVENT;
	assign seen = {6'h0, is_evt ? {svc.src, svc.dst, svc.channel, svc.byte_move} : 36'h0, svc.kind,
		is_evt ? 16'h0 : {svc.trap_num, svc.vector}, svc.push_words, exec_stall};

	vit_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .instr_end, .seg_mode, .periph_req, .fast_pin, .fast_alt_en, .nmi_pin_n, .stk_overflow,
		.stk_underflow, .classb_evt, .sw_trap_req, .sw_trap_num, .clk_sup_evt, .rtc_evt, .svc, .exec_stall,
		.cpu_level);
	vit_cpu_model cpu (.pclk, .presetn, .exec_stall, .slow, .instr_end);

	always #50 pclk = ~pclk;

	// ----------------------------------------
	// checking helpers
	// ----------------------------------------
	task automatic chk(input logic [63:0] s, input logic [63:0] x);
		compares++;
		if (s !== x) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic summarize;
		if (n_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// a hang would otherwise stall the run forever
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			summarize;
		end
	end
	// every service request is matched against the oldest expectation
	always @(posedge pclk) begin
		if (presetn && svc.valid === 1'h1) begin
			if (expq.size() == 0) chk(seen, 64'h0);
			else chk(seen, expq.pop_front());
		end
	end
	function automatic logic [63:0] ex(input logic [2:0] k, input logic [6:0] n, input logic [1:0] p,
		input logic [35:0] ev);
		return {6'h0, ev, k, n, n, 2'h0, p, k == vit_pkg::KIND_EVENT};
	endfunction
	function automatic logic [6:0] ntrap(input int n);
		return (n < 4) ? 7'(8'h18 + n) : vit_pkg::NODE_TRAP[n];
	endfunction
	task automatic exp_node(input int n);
		expq.push_back(ex(vit_pkg::KIND_VECTOR, ntrap(n), seg_mode ? vit_pkg::PUSH_SEG : vit_pkg::PUSH_FLAT, 36'h0));
	endtask
	task automatic settle(input int g);
		for (int i = 0; i < 60 && expq.size() != 0; i++) @(posedge pclk);
		repeat (g) @(posedge pclk);
		chk(64'(expq.size()), 64'h0);
		expq.delete();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [63:0] r);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = {31'h0, pslverr, prdata};
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [63:0] r;
		apb(1'h1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [63:0] r;
		apb(1'h0, a, 32'h0, r);
		chk(r, {31'h0, xe, x});
	endtask
	task automatic setcpu(input logic [3:0] l, input logic g);
		wr(vit_pkg::OFS_CPU_PRIO, {27'h0, g, l});
	endtask
	task automatic pulse_req(input logic [31:0] m);
		@(posedge pclk);
		periph_req <= m;
		@(posedge pclk);
		periph_req <= 32'h0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(36));
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		rd(12'h000, 32'h0, 1'h0);
		rd(12'h090, 32'h0, 1'h1);
		wr(12'h00C, 32'h0000_FF3C);
		rd(12'h00C, 32'h0000_003C, 1'h0);
		for (int n = 0; n < 32; n++) begin
			lv = 4'(1 + $urandom % 13);
			gp = 2'($urandom);
			seg_mode <= 1'($urandom);
			slow <= 1'($urandom);
			setcpu(4'h0, 1'h1);
			wr(12'(n * 4), {24'h0, 2'h1, lv, gp});
			exp_node(n);
			pulse_req(32'h1 << n);
			settle(4);
			chk(64'(cpu_level), 64'(lv));
			rd(12'(n * 4), {24'h0, 2'h1, lv, gp}, 1'h0);
		end
		seg_mode <= 1'h0;
		setcpu(4'h0, 1'h0);
		wr(12'h014, 32'h0000_00D8);
		wr(12'h01C, 32'h0000_00E5);
		wr(12'h020, 32'h0000_00E6);
		wr(12'h024, 32'h0000_00C0);
		settle(6);
		exp_node(8);
		setcpu(4'h6, 1'h1);
		settle(6);
		exp_node(7);
		setcpu(4'h0, 1'h1);
		settle(6);
		exp_node(5);
		setcpu(4'h0, 1'h1);
		settle(6);
		wr(12'h024, 32'h0);
		for (int i = 0; i < 4; i++) begin
			lv = (i == 2) ? 4'hD : 4'hE + 4'(i & 1);
			gp = 2'($urandom);
			ch = {lv[0], gp};
			bm = 8'($urandom);
			sd = $urandom;
			setcpu(4'h0, 1'h1);
			wr(vit_pkg::OFS_EVT_CTRL, {16'h0, bm, (i == 3) ? 8'h00 : 8'hFF});
			wr({vit_pkg::OFS_CHAN_BASE[11:5], ch, 2'h0}, sd);
			wr(12'h030, {24'h0, 2'h1, lv, gp});
			if (i < 2) expq.push_back(ex(vit_pkg::KIND_EVENT, 7'h0, 2'h0, {sd[15:0], sd[31:16], ch, bm[ch]}));
			else exp_node(12);
			pulse_req(32'h0000_1000);
			settle(4);
			chk(64'(cpu_level), (i < 2) ? 64'h0 : 64'(lv));
		end
		setcpu(4'h0, 1'h0);
		expq.push_back(ex(vit_pkg::KIND_TRAP, vit_pkg::TRAP_NMI, vit_pkg::PUSH_FLAT, 36'h0));
		@(posedge pclk);
		nmi_pin_n <= 1'h0;
		settle(4);
		nmi_pin_n <= 1'h1;
		chk(64'(cpu_level), 64'h0);
		rd(vit_pkg::OFS_TRAP_FLAGS, 32'h0000_0001, 1'h0);
		wr(vit_pkg::OFS_TRAP_FLAGS, 32'h0000_00FF);
		rd(vit_pkg::OFS_TRAP_FLAGS, 32'h0, 1'h0);
		for (int k = 0; k < 5; k++) begin
			if (k == 0) expq.push_back(ex(vit_pkg::KIND_TRAP, vit_pkg::TRAP_STKOF, vit_pkg::PUSH_FLAT, 36'h0));
			expq.push_back(ex(vit_pkg::KIND_TRAP, vit_pkg::TRAP_CLASSB, vit_pkg::PUSH_FLAT, 36'h0));
			@(posedge pclk);
			classb_evt <= 5'h1 << k;
			stk_overflow <= (k == 0);
			@(posedge pclk);
			classb_evt <= 5'h0;
			stk_overflow <= 1'h0;
			settle(4);
			rd(vit_pkg::OFS_TRAP_FLAGS, (32'h8 << k) | ((k == 0) ? 32'h2 : 32'h0), 1'h0);
			wr(vit_pkg::OFS_TRAP_FLAGS, 32'h0000_00FF);
		end
		setcpu(4'h0, 1'h1);
		wr(12'h008, 32'h0000_004C);
		expq.push_back(ex(vit_pkg::KIND_TRAP, vit_pkg::TRAP_STKUF, vit_pkg::PUSH_FLAT, 36'h0));
		exp_node(2);
		@(posedge pclk);
		stk_underflow <= 1'h1;
		periph_req <= 32'h4;
		@(posedge pclk);
		stk_underflow <= 1'h0;
		periph_req <= 32'h0;
		settle(4);
		chk(64'(cpu_level), 64'h3);
		wr(vit_pkg::OFS_TRAP_FLAGS, 32'h0000_00FF);
		setcpu(4'h7, 1'h1);
		for (int i = 0; i < 4; i++) begin
			sw_trap_num <= 7'($urandom);
			@(posedge pclk);
			expq.push_back(ex(vit_pkg::KIND_TRAP, sw_trap_num, vit_pkg::PUSH_FLAT, 36'h0));
			sw_trap_req <= 1'h1;
			@(posedge pclk);
			sw_trap_req <= 1'h0;
			settle(4);
			chk(64'(cpu_level), 64'h7);
		end
		setcpu(4'h0, 1'h1);
		wr(12'h004, 32'h0000_0048);
		fast_pin <= 4'h2;
		settle(10);
		fast_pin <= 4'h0;
		settle(6);
		fast_alt_en <= 4'h2;
		settle(6);
		exp_node(1);
		fast_pin <= 4'h2;
		settle(6);
		fast_pin <= 4'h0;
		for (int i = 0; i < 2; i++) begin
			setcpu(4'h0, 1'h1);
			wr(12'h06C, 32'h0000_0048);
			wr(vit_pkg::OFS_SUBNODE, 32'h1 << (2 * i));
			exp_node(27);
			@(posedge pclk);
			clk_sup_evt <= (i == 0);
			rtc_evt <= (i == 1);
			@(posedge pclk);
			clk_sup_evt <= 1'h0;
			rtc_evt <= 1'h0;
			settle(4);
			rd(vit_pkg::OFS_SUBNODE, 32'h3 << (2 * i), 1'h0);
		end
		summarize;
	end
endmodule
`default_nettype wire
